// File: design/adcs_device.sv
// Overview of operation
// - Chip select falling presents the first bit.
// - Forty ones on data input reset everything.
// - Host waits 500 us after any reset.
// - Reset clears conversion engine; also at power-up.
// - Mode 001 converts once then powers down.
// - Single conversion waits for oscillator start-up first.
// - Ready rises after read; stays high until next.
// - Single mode converts each enabled channel once.
// - Append bit adds status holding the channel.
// - Continuous mode at power-up; ready falls per result.
// - Result completing during data read outside continuous read is discarded.
// - Continuous mode loops through enabled channels.
// - Command 01011100 enters continuous read.
// - Unread result is replaced by the next one.
// - Command 01011000 while ready low exits continuous read.
// - Forty ones still reset during continuous read.
// - Sync low holds modulator and filter reset.
// - Host holds sync low four clocks minimum.
// - Sync reset ends on next clock edge.
// - Host raises sync on its own clock edge.
// - Sync rising edge starts a fresh conversion.
// - Every transaction except a continuous-read data read begins with a command byte.
// - Ready rises before each data register update.
module adcs_device
	import adcs_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYC_DEF,
	parameter int WARM_CYC = OSC_CYC
)
(
	input  wire logic              clk,
	input  wire logic              nrst,
	adcs_if.dev                    link,
	input  wire logic [DATA_W-1:0] sample,
	output logic                   conv_pulse,
	output logic                   cread_on
);

	localparam int MX = CONV_CYC > WARM_CYC ? CONV_CYC : WARM_CYC;
	localparam int CW = $clog2(MX + 1);

	if (CONV_CYC < 3 || WARM_CYC < 1)
		$error("adcs_device: cycle counts too small");

	function automatic logic [2:0] lowest(input logic [NCH-1:0] m);
		logic [2:0] r;
		r = 3'h0;
		for (int i = NCH - 1; i >= 0; i--)
			if (m[i])
				r = 3'(i);
		return r;
	endfunction

	function automatic logic [5:0] reg_bits(input logic [2:0] a,
		input logic app);
		case (a)
			A_STATUS: return 6'h08;
			A_DATA:   return app ? 6'h20 : 6'h18;
			default:  return 6'h18;
		endcase
	endfunction

	logic [1:0]        sclk_s;
	logic [1:0]        cs_s;
	logic [1:0]        din_s;
	logic [1:0]        sync_s;
	logic              sclk_d;
	logic              sync_d;
	logic              rise;
	logic              din_v;
	logic              cs_lo;
	logic              sync_lo;
	logic              sync_rise;
	logic [5:0]        ones_r;
	logic              srst_r;
	adcs_ser_type      ser_r;
	logic [2:0]        addr_r;
	logic [5:0]        left_r;
	logic [7:0]        in_sh_r;
	logic [22:0]       wr_sh_r;
	logic [31:0]       out_sh_r;
	logic [2:0]        cr_cnt_r;
	logic              cread_r;
	logic [23:0]       mode_r;
	logic [23:0]       cfg_r;
	adcs_conv_type     cv_r;
	logic [CW-1:0]     cnt_r;
	logic [2:0]        ch_r;
	logic [NCH-1:0]    pend_r;
	logic [DATA_W-1:0] data_r;
	logic [2:0]        stat_ch_r;
	logic              rdy_n_r;
	logic [7:0]        byte_nxt;
	logic [23:0]       wr_val;
	logic [2:0]        cmd_addr;
	logic [31:0]       rd_word;
	logic [7:0]        stat_val;
	logic              app;
	logic              complete;
	logic              pre_upd;
	logic              reading_data;
	logic              load_cr;
	logic              wr_done;
	logic              rd_done;
	logic              restart;
	logic [2:0]        new_opm;
	logic [NCH-1:0]    new_mask;
	logic [NCH-1:0]    cur_mask;
	logic [NCH-1:0]    rem_mask;

	// ---------------------------------------------------------------
	// Pin synchronisers and edge detection.
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sclk_s <= 2'h3;
			cs_s   <= 2'h3;
			din_s  <= 2'h0;
			sync_s <= 2'h3;
			sclk_d <= 1'h1;
			sync_d <= 1'h1;
		end
		else
		begin
			sclk_s <= {sclk_s[0], link.sclk};
			cs_s   <= {cs_s[0], link.cs_n};
			din_s  <= {din_s[0], link.din};
			sync_s <= {sync_s[0], link.sync_n};
			sclk_d <= sclk_s[1];
			sync_d <= sync_s[1];
		end
	end

	assign cs_lo     = ~cs_s[1];
	assign rise      = sclk_s[1] & ~sclk_d & cs_lo;
	assign din_v     = din_s[1];
	assign sync_lo   = ~sync_s[1];
	assign sync_rise = sync_s[1] & ~sync_d;

	// ---------------------------------------------------------------
	// Serial reset detector.
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ones_r <= 6'h00;
			srst_r <= 1'h0;
		end
		else
		begin
			srst_r <= 1'h0;
			if (rise)
			begin
				if (!din_v)
					ones_r <= 6'h00;
				else if (ones_r == 6'(RESET_ONES - 1))
				begin
					ones_r <= 6'h00;
					srst_r <= 1'h1;
				end
				else
					ones_r <= ones_r + 6'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// Decode helpers.
	// ---------------------------------------------------------------
	assign app          = mode_r[MODE_APPEND_BIT];
	assign byte_nxt     = {in_sh_r[6:0], din_v};
	assign wr_val       = {wr_sh_r, din_v};
	assign cmd_addr     = byte_nxt[COMM_ADDR_LSB +: 3];
	assign stat_val     = {rdy_n_r, 4'h0, stat_ch_r};
	assign complete     = cv_r == CV_RUN && cnt_r == CW'(CONV_CYC - 1);
	assign pre_upd      = cv_r == CV_RUN && cnt_r == CW'(CONV_CYC - 2);
	assign reading_data = ser_r == SER_RD && addr_r == A_DATA && !cread_r;
	assign load_cr      = complete && cread_r;
	assign wr_done      = rise && !load_cr && ser_r == SER_WR
		&& left_r == 6'h01;
	assign rd_done      = rise && !load_cr && ser_r == SER_RD
		&& left_r == 6'h01 && addr_r == A_DATA;
	assign restart      = sync_rise
		|| (wr_done && (addr_r == A_MODE || addr_r == A_CONFIG));
	assign new_opm      = (wr_done && addr_r == A_MODE)
		? wr_val[MODE_OPM_LSB +: 3] : mode_r[MODE_OPM_LSB +: 3];
	assign new_mask     = (wr_done && addr_r == A_CONFIG)
		? wr_val[CFG_CH_LSB +: NCH] : cfg_r[CFG_CH_LSB +: NCH];
	assign cur_mask     = cfg_r[CFG_CH_LSB +: NCH];
	assign rem_mask     = pend_r & ~(NCH'(1) << ch_r);

	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (cmd_addr)
			A_STATUS: rd_word = {stat_val, 24'h00_0000};
			A_MODE:   rd_word = {mode_r, 8'h00};
			A_CONFIG: rd_word = {cfg_r, 8'h00};
			A_DATA:   rd_word = {data_r, app ? stat_val : 8'h00};
			default:  rd_word = 32'h0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// Serial command and shift engine.
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ser_r    <= SER_CMD;
			addr_r   <= A_STATUS;
			left_r   <= 6'h08;
			in_sh_r  <= 8'h00;
			wr_sh_r  <= 23'h00_0000;
			out_sh_r <= 32'h0000_0000;
			cr_cnt_r <= 3'h0;
			cread_r  <= 1'h0;
		end
		else if (srst_r)
		begin
			ser_r    <= SER_CMD;
			addr_r   <= A_STATUS;
			left_r   <= 6'h08;
			in_sh_r  <= 8'h00;
			wr_sh_r  <= 23'h00_0000;
			out_sh_r <= 32'h0000_0000;
			cr_cnt_r <= 3'h0;
			cread_r  <= 1'h0;
		end
		else if (load_cr)
		begin
			out_sh_r <= {sample, app ? {5'h00, ch_r} : 8'h00};
			ser_r    <= SER_RD;
			addr_r   <= A_DATA;
			left_r   <= reg_bits(A_DATA, app);
			cr_cnt_r <= 3'h0;
		end
		else if (!cs_lo && !cread_r)
		begin
			ser_r  <= SER_CMD;
			left_r <= 6'h08;
		end
		else if (rise)
		begin
			in_sh_r  <= byte_nxt;
			cr_cnt_r <= cr_cnt_r + 3'h1;
			left_r <= left_r - 6'h01;
			case (ser_r)
				SER_CMD:
				begin
					if (left_r == 6'h01)
					begin
						left_r <= 6'h08;
						if (!cread_r && !byte_nxt[COMM_WEN_BIT])
						begin
							addr_r <= cmd_addr;
							left_r <= reg_bits(cmd_addr, app);
							if (byte_nxt == CMD_CREAD_ON)
							begin
								cread_r  <= 1'h1;
								cr_cnt_r <= 3'h0;
								left_r   <= 6'h08;
							end
							else if (byte_nxt[COMM_RD_BIT])
							begin
								ser_r    <= SER_RD;
								out_sh_r <= rd_word;
							end
							else
								ser_r <= SER_WR;
						end
					end
				end
				SER_WR:
				begin
					wr_sh_r <= wr_val[22:0];
					if (left_r == 6'h01)
					begin
						ser_r  <= SER_CMD;
						left_r <= 6'h08;
					end
				end
				SER_RD:
				begin
					out_sh_r <= {out_sh_r[30:0], 1'h0};
					if (left_r == 6'h01)
					begin
						ser_r  <= SER_CMD;
						left_r <= 6'h08;
					end
				end
				default:
				begin
					ser_r <= SER_CMD;
				end
			endcase
			// Leaving continuous read drops any half-read result.
			if (cread_r && cr_cnt_r == 3'h7 && byte_nxt == CMD_CREAD_OFF)
			begin
				cread_r <= 1'h0;
				ser_r   <= SER_CMD;
				left_r  <= 6'h08;
			end
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers.
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_r <= MODE_RST;
			cfg_r  <= CFG_RST;
		end
		else if (srst_r)
		begin
			mode_r <= MODE_RST;
			cfg_r  <= CFG_RST;
		end
		else if (wr_done && addr_r == A_MODE)
			mode_r <= wr_val;
		else if (wr_done && addr_r == A_CONFIG)
			cfg_r <= wr_val;
	end

	// ---------------------------------------------------------------
	// Conversion sequencer.
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cv_r       <= CV_RUN;
			cnt_r      <= '0;
			ch_r       <= 3'h0;
			pend_r     <= CFG_RST[CFG_CH_LSB +: NCH];
			data_r     <= 24'h00_0000;
			stat_ch_r  <= 3'h0;
			rdy_n_r    <= 1'h1;
			conv_pulse <= 1'h0;
		end
		else if (srst_r)
		begin
			cv_r       <= CV_RUN;
			cnt_r      <= '0;
			ch_r       <= 3'h0;
			pend_r     <= CFG_RST[CFG_CH_LSB +: NCH];
			data_r     <= 24'h00_0000;
			stat_ch_r  <= 3'h0;
			rdy_n_r    <= 1'h1;
			conv_pulse <= 1'h0;
		end
		else
		begin
			conv_pulse <= 1'h0;
			cnt_r      <= cnt_r + 1'h1;
			if (rd_done)
				rdy_n_r <= 1'h1;
			if (sync_lo)
			begin
				cv_r  <= CV_HOLD;
				cnt_r <= '0;
			end
			else if (restart)
			begin
				cnt_r   <= '0;
				rdy_n_r <= 1'h1;
				pend_r  <= new_mask == '0 ? NCH'(1) : new_mask;
				ch_r    <= lowest(new_mask);
				if (new_opm == OPM_CONT)
					cv_r <= CV_RUN;
				else if (new_opm == OPM_SINGLE)
					cv_r <= CV_WARM;
				else
					cv_r <= CV_OFF;
			end
			else
			begin
				case (cv_r)
					CV_WARM:
					begin
						if (cnt_r == CW'(WARM_CYC - 1))
						begin
							cnt_r <= '0;
							cv_r  <= CV_RUN;
						end
					end
					CV_RUN:
					begin
						if (pre_upd)
							rdy_n_r <= 1'h1;
						if (complete)
						begin
							cnt_r <= '0;
							if (!reading_data)
							begin
								data_r     <= sample;
								stat_ch_r  <= ch_r;
								rdy_n_r    <= 1'h0;
								conv_pulse <= 1'h1;
							end
							if (rem_mask != '0)
							begin
								pend_r <= rem_mask;
								ch_r   <= lowest(rem_mask);
							end
							else if (mode_r[MODE_OPM_LSB +: 3] == OPM_SINGLE)
								cv_r <= CV_OFF;
							else
							begin
								pend_r <= cur_mask == '0 ? NCH'(1) : cur_mask;
								ch_r   <= lowest(cur_mask);
							end
						end
					end
					CV_OFF, CV_HOLD:
					begin
						cnt_r <= '0;
					end
					default:
					begin
						cv_r <= CV_OFF;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Output pins.
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			link.dout    <= 1'h1;
			link.dout_oe <= 1'h0;
			cread_on     <= 1'h0;
		end
		else
		begin
			link.dout_oe <= cs_lo;
			cread_on     <= cread_r;
			if (ser_r == SER_RD)
				link.dout <= out_sh_r[31];
			else
				link.dout <= rdy_n_r;
		end
	end

endmodule

// File: design/adcs_host.sv
module adcs_host
	import adcs_pkg::*;
#(
	parameter int HALF     = HALF_DEF,
	parameter int WAIT_CYC = RST_WAIT_CYC,
	parameter int SYNC_LOW = SYNC_LOW_DEF
)
(
	input  wire logic        clk,
	input  wire logic        nrst,
	adcs_if.host             link,
	input  wire logic        go,
	input  wire logic        skip_cmd,
	input  wire logic [7:0]  cmd,
	input  wire logic [31:0] wdata,
	input  wire logic [2:0]  nbytes,
	input  wire logic        reset_go,
	input  wire logic        sync_go,
	input  wire logic        hold_cs,
	output logic             busy,
	output logic             done,
	output logic [31:0]      rdata,
	output logic             ready_n
);

	localparam int MX = WAIT_CYC > SYNC_LOW ? WAIT_CYC : SYNC_LOW;
	localparam int TW = $clog2(MX + 1);

	if (HALF < 3 || SYNC_LOW < SYNC_LOW_MIN || WAIT_CYC < 1 || HALF > MX)
		$error("adcs_host: unusable timing parameters");

	adcs_host_type    st_r;
	logic [TW-1:0]    tmr_r;
	logic [5:0]       bits_r;
	logic [40:0]      tx_r;
	logic [31:0]      rx_r;
	logic             rst_seq_r;
	logic [1:0]       dout_s;
	logic             exit_blocked;

	// ---------------------------------------------------------------
	// Data line synchroniser.
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dout_s  <= 2'h3;
			ready_n <= 1'h1;
		end
		else
		begin
			dout_s  <= {dout_s[0], link.dout_line};
			ready_n <= dout_s[1];
		end
	end

	assign exit_blocked = cmd == CMD_CREAD_OFF && !skip_cmd && ready_n;

	// ---------------------------------------------------------------
	// Transfer sequencer.
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r        <= H_WAIT;
			tmr_r       <= '0;
			bits_r      <= 6'h00;
			tx_r        <= '0;
			rx_r        <= 32'h0000_0000;
			rst_seq_r   <= 1'h0;
			link.sclk   <= 1'h1;
			link.cs_n   <= 1'h1;
			link.din    <= 1'h0;
			link.sync_n <= 1'h1;
			busy        <= 1'h1;
			done        <= 1'h0;
			rdata       <= 32'h0000_0000;
		end
		else
		begin
			done  <= 1'h0;
			tmr_r <= tmr_r + 1'h1;
			case (st_r)
				H_IDLE:
				begin
					tmr_r     <= '0;
					busy      <= 1'h0;
					link.cs_n <= ~hold_cs;
					if (reset_go)
					begin
						tx_r      <= '1;
						bits_r    <= 6'(RESET_BITS + 1);
						rst_seq_r <= 1'h1;
						link.cs_n <= 1'h0;
						busy      <= 1'h1;
						st_r      <= H_HIGH;
					end
					else if (sync_go)
					begin
						link.sync_n <= 1'h0;
						busy        <= 1'h1;
						st_r        <= H_SYNC;
					end
					else if (go && !exit_blocked)
					begin
						// Read payload bits keep the data line low.
						if (skip_cmd)
							tx_r <= '0;
						else if (cmd[COMM_RD_BIT])
							tx_r <= {1'h0, cmd, 32'h0000_0000};
						else
							tx_r <= {1'h0, cmd, wdata};
						bits_r    <= {nbytes, 3'h0} + (skip_cmd ? 6'h01 : 6'h09);
						link.cs_n <= 1'h0;
						busy      <= 1'h1;
						st_r      <= H_HIGH;
					end
				end
				H_WAIT:
				begin
					busy <= 1'h1;
					if (tmr_r == TW'(WAIT_CYC - 1))
					begin
						rst_seq_r <= 1'h0;
						st_r      <= H_IDLE;
					end
				end
				H_SYNC:
				begin
					if (tmr_r == TW'(SYNC_LOW - 1))
					begin
						link.sync_n <= 1'h1;
						done        <= 1'h1;
						st_r        <= H_IDLE;
					end
				end
				H_LOW:
				begin
					if (tmr_r == TW'(HALF - 1))
					begin
						tmr_r     <= '0;
						link.sclk <= 1'h1;
						rx_r      <= {rx_r[30:0], dout_s[1]};
						st_r      <= H_HIGH;
					end
				end
				H_HIGH:
				begin
					if (tmr_r == TW'(HALF - 1))
					begin
						tmr_r <= '0;
						if (bits_r == 6'h01)
						begin
							link.cs_n <= rst_seq_r | ~hold_cs;
							link.din  <= 1'h0;
							done      <= 1'h1;
							rdata     <= rx_r;
							st_r      <= rst_seq_r ? H_WAIT : H_IDLE;
						end
						else
						begin
							bits_r    <= bits_r - 6'h01;
							tx_r      <= {tx_r[39:0], rst_seq_r};
							link.din  <= tx_r[39];
							link.sclk <= 1'h0;
							st_r      <= H_LOW;
						end
					end
				end
				default:
				begin
					st_r <= H_IDLE;
				end
			endcase
		end
	end

endmodule

// File: inc/adcs_if.sv
interface adcs_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic sync_n;
	logic dout;
	logic dout_oe;
	logic dout_line;

	// The data line idles high when the device does not drive it.
	assign dout_line = dout_oe ? dout : 1'h1;

	modport dev
	(
		input  sclk,
		input  cs_n,
		input  din,
		input  sync_n,
		output dout,
		output dout_oe
	);

	modport host
	(
		output sclk,
		output cs_n,
		output din,
		output sync_n,
		input  dout_line
	);
endinterface

// File: inc/adcs_pkg.sv
package adcs_pkg;

	// ---------------------------------------------------------------
	// Timing.
	// ---------------------------------------------------------------
	localparam int CLK_HZ       = 10_000_000;
	localparam int RST_WAIT_US  = 500;
	localparam int RST_WAIT_CYC = (RST_WAIT_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int OSC_US       = 1000;
	localparam int OSC_CYC      = (OSC_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int SYNC_LOW_MIN = 4;
	localparam int SYNC_LOW_DEF = 8;
	localparam int HALF_DEF     = 4;
	localparam int CONV_CYC_DEF = 2000;
	localparam int RESET_ONES   = 40;
	localparam int RESET_BITS   = 48;

	// ---------------------------------------------------------------
	// Widths and commands.
	// ---------------------------------------------------------------
	localparam int DATA_W = 24;
	localparam int NCH    = 8;
	localparam logic [7:0] CMD_CREAD_ON  = 8'h5c;
	localparam logic [7:0] CMD_CREAD_OFF = 8'h58;
	localparam int COMM_WEN_BIT   = 7;
	localparam int COMM_RD_BIT    = 6;
	localparam int COMM_ADDR_LSB  = 3;
	localparam int COMM_CREAD_BIT = 2;

	// ---------------------------------------------------------------
	// Register addresses and fields.
	// ---------------------------------------------------------------
	localparam logic [2:0] A_STATUS = 3'h0;
	localparam logic [2:0] A_MODE   = 3'h1;
	localparam logic [2:0] A_CONFIG = 3'h2;
	localparam logic [2:0] A_DATA   = 3'h3;
	localparam int MODE_OPM_LSB    = 21;
	localparam int MODE_APPEND_BIT = 20;
	localparam int CFG_CH_LSB      = 8;
	localparam logic [23:0] MODE_RST = 24'h00_0000;
	localparam logic [23:0] CFG_RST  = 24'h00_0100;
	localparam logic [2:0]  OPM_CONT   = 3'h0;
	localparam logic [2:0]  OPM_SINGLE = 3'h1;

	// ---------------------------------------------------------------
	// State types.
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		SER_CMD = 3'h1,
		SER_WR  = 3'h2,
		SER_RD  = 3'h4
	} adcs_ser_type;

	typedef enum logic [3:0] {
		CV_OFF  = 4'h1,
		CV_WARM = 4'h2,
		CV_RUN  = 4'h4,
		CV_HOLD = 4'h8
	} adcs_conv_type;

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_WAIT = 5'h02,
		H_SYNC = 5'h04,
		H_LOW  = 5'h08,
		H_HIGH = 5'h10
	} adcs_host_type;

endpackage

// File: sim/adcs_properties.sv
module adcs_properties
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic sync_n,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic dout_line
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Link checks.
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence low_phase_s;
		(!sclk)[*4];
	endsequence

	sequence high_phase_s;
		sclk[*4];
	endsequence

	sequence sync_long_s;
		(!sync_n)[*4];
	endsequence

	oe_follow_a: assert property (dout_oe == !$past(cs_n, 3))
		else $error("dout_oe does not follow chip select");
	idle_high_a: assert property ($past(cs_n, 3) |-> dout_line)
		else $error("data line not high while deselected");
	sclk_idle_a: assert property (cs_n |-> sclk)
		else $error("serial clock low while deselected");
	cs_first_a: assert property ($fell(cs_n) |-> high_phase_s)
		else $error("serial clock moved too soon after select");
	low_half_a: assert property ($fell(sclk) |-> low_phase_s ##1 sclk)
		else $error("serial clock low phase has wrong length");
	high_half_a: assert property ($rose(sclk) |-> high_phase_s)
		else $error("serial clock high phase too short");
	sync_width_a: assert property ($fell(sync_n) |-> sync_long_s)
		else $error("sync pulse shorter than four clocks");
	sync_hold_a: assert property (!sync_n && !$past(sync_n, 6)
		&& dout_oe && $past(dout_oe) |-> !$fell(dout))
		else $error("result signalled while sync held low");
endmodule

// File: sim/adcs_tb.sv
module adc_conversion_and_serial_control_tb
	import adcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Signals and instances.
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] m;
		logic [31:0] v;
	} adcs_note_type;
	localparam int CONV = 600;
	localparam int WARM = 10;
	logic              clk, nrst, go, skip_cmd, reset_go, sync_go, hold_cs;
	logic              busy, done, ready_n, conv_pulse, cread_on;
	logic [7:0]        cmd;
	logic [31:0]       wdata, rdata;
	logic [2:0]        nbytes;
	logic [DATA_W-1:0] sample;
	int                mismatches, checks, cyc, dt, npulse, p0;
	adcs_note_type     notes[$];
	adcs_note_type     nt;

	adcs_if adcs_if_i();
	adcs_host #(.HALF(4), .WAIT_CYC(20), .SYNC_LOW(8)) adcs_host_i
	(
		.clk(clk), .nrst(nrst), .link(adcs_if_i), .go(go),
		.skip_cmd(skip_cmd), .cmd(cmd), .wdata(wdata), .nbytes(nbytes),
		.reset_go(reset_go), .sync_go(sync_go), .hold_cs(hold_cs),
		.busy(busy), .done(done), .rdata(rdata), .ready_n(ready_n)
	);
	adcs_device #(.CONV_CYC(CONV), .WARM_CYC(WARM)) adcs_device_i
	(
		.clk(clk), .nrst(nrst), .link(adcs_if_i), .sample(sample),
		.conv_pulse(conv_pulse), .cread_on(cread_on)
	);
	adcs_properties adcs_properties_i
	(
		.clk(clk), .nrst(nrst), .sclk(adcs_if_i.sclk),
		.cs_n(adcs_if_i.cs_n), .din(adcs_if_i.din),
		.sync_n(adcs_if_i.sync_n), .dout(adcs_if_i.dout),
		.dout_oe(adcs_if_i.dout_oe), .dout_line(adcs_if_i.dout_line)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) cyc <= cyc + 1;
	always @(negedge clk) if (conv_pulse === 1'b1) npulse++;

	// ----------------------------------------
	// Tasks.
	// ----------------------------------------
	task automatic close_out();
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cmp_word(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cmp_bit(input string nm, input logic e, input logic s);
		cmp_word(nm, {31'h0, e}, {31'h0, s});
	endtask

	task automatic run(input logic [7:0] c, input logic sk,
		input logic [2:0] nb, input logic [31:0] wd, input logic rg,
		input logic sg, input logic [31:0] m, input logic [31:0] v);
		int n;
		for (n = 0; n < 9000 && busy !== 1'b0; n++) @(negedge clk);
		notes.push_back('{m, v});
		@(posedge clk);
		cmd <= c;
		skip_cmd <= sk;
		nbytes <= nb;
		wdata <= wd;
		reset_go <= rg;
		sync_go <= sg;
		go <= !(rg || sg);
		@(posedge clk);
		go <= 1'b0;
		reset_go <= 1'b0;
		sync_go <= 1'b0;
		for (n = 0; n < 9000 && done !== 1'b1; n++) @(negedge clk);
		cmp_bit("done", 1'b1, done);
	endtask

	task automatic wait_rdy();
		int n;
		repeat (8) @(negedge clk);
		for (n = 0; n < 3000 && ready_n !== 1'b0; n++) @(negedge clk);
		cmp_bit("ready_low", 1'b0, ready_n);
	endtask

	task automatic wait_conv(output int d);
		int n;
		int t;
		t = cyc;
		@(negedge clk);
		for (n = 0; n < 3000 && conv_pulse !== 1'b1; n++) @(negedge clk);
		cmp_bit("conv", 1'b1, conv_pulse);
		d = cyc - t;
	endtask

	task automatic new_sample();
		@(posedge clk);
		// The top bit stays clear so that a result loaded in continuous
		// read shows the line low, which the exit command waits for.
		sample <= DATA_W'($urandom) >> 1;
	endtask

	always @(negedge clk)
	begin
		if (done === 1'b1 && notes.size() > 0)
		begin
			nt = notes.pop_front();
			if (nt.m !== 32'h0000_0000)
				cmp_word("rdata", nt.v, rdata & nt.m);
		end
	end

	// ----------------------------------------
	// Tests.
	// ----------------------------------------
	initial
	begin
		void'($urandom(57703));
		{nrst, go, skip_cmd, reset_go, sync_go, hold_cs} = 6'h00;
		{cmd, wdata, nbytes, sample} = '0;
		{mismatches, checks, cyc, npulse} = '0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		hold_cs <= 1'b1;
		new_sample();
		run(8'h10, 1'b0, 3'h3, 32'h0006_0000, 1'b0, 1'b0, '0, '0);
		run(8'h08, 1'b0, 3'h3, 32'h3000_0000, 1'b0, 1'b0, '0, '0);
		p0 = npulse;
		wait_conv(dt);
		cmp_bit("warm", 1'b1, dt >= WARM + CONV - 4 && dt <= WARM + CONV + 12);
		for (int ch = 1; ch <= 2; ch++)
		begin
			wait_rdy();
			run(8'h58, 1'b0, 3'h4, '0, 1'b0, 1'b0, 32'hffff_ffff,
				{sample, 5'h00, 3'(ch)});
		end
		repeat (2 * CONV) @(negedge clk);
		cmp_bit("ready", 1'b1, ready_n);
		cmp_word("pulses", 32'h0000_0002, 32'(npulse - p0));
		new_sample();
		run(8'h08, 1'b0, 3'h3, '0, 1'b0, 1'b0, '0, '0);
		run(CMD_CREAD_ON, 1'b0, 3'h0, '0, 1'b0, 1'b0, '0, '0);
		cmp_bit("cread", 1'b1, cread_on);
		wait_rdy();
		run(8'h00, 1'b1, 3'h3, '0, 1'b0, 1'b0, 32'h00ff_ffff, {8'h00, sample});
		wait_conv(dt);
		new_sample();
		wait_conv(dt);
		wait_rdy();
		run(8'h00, 1'b1, 3'h3, '0, 1'b0, 1'b0, 32'h00ff_ffff, {8'h00, sample});
		wait_rdy();
		run(CMD_CREAD_OFF, 1'b0, 3'h0, '0, 1'b0, 1'b0, '0, '0);
		cmp_bit("cread", 1'b0, cread_on);
		run(8'h00, 1'b0, 3'h0, '0, 1'b0, 1'b1, '0, '0);
		wait_conv(dt);
		cmp_bit("sync", 1'b1, dt >= CONV - 4 && dt <= CONV + 12);
		run(CMD_CREAD_ON, 1'b0, 3'h0, '0, 1'b0, 1'b0, '0, '0);
		cmp_bit("cread", 1'b1, cread_on);
		run(8'h00, 1'b0, 3'h0, '0, 1'b1, 1'b0, '0, '0);
		cmp_bit("cread", 1'b0, cread_on);
		@(posedge clk);
		hold_cs <= 1'b0;
		run(8'h50, 1'b0, 3'h3, '0, 1'b0, 1'b0, 32'h00ff_ffff, {8'h00, CFG_RST});
		run(8'h48, 1'b0, 3'h3, '0, 1'b0, 1'b0, 32'h00ff_ffff, {8'h00, MODE_RST});
		close_out();
	end

	initial
	begin
		repeat (40000) @(posedge clk);
		mismatches++;
		close_out();
	end
endmodule
